// *** bist_pkg.sv ***
// shared constants and types for the built-in self test unit
package bist_pkg;
    // ------------------------------------------------------------
    // clock and beep timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100; // system clock rate in MHz
    localparam int BEEP_MS = 200; // one beep, and one gap, in milliseconds
    localparam int BEEP_CYC = BEEP_MS * 1000 * CLK_MHZ; // beep length in cycles

    // ------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam int AW = 8; // apb address width
    localparam logic [7:0] OFS_CTRL = 8'h00; // write-only test start
    localparam logic [7:0] OFS_STATUS = 8'h04; // read-only unit state
    localparam logic [7:0] OFS_RESULT = 8'h08; // read-only result word
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C; // read-only sticky events
    localparam logic [7:0] OFS_IRQ_EN = 8'h10; // read-write event enables
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14; // write-only event clear
    localparam int CTRL_CONF = 0; // start confidence test
    localparam int CTRL_FULL = 1; // start full instrument test
    localparam int RES_W = 10; // result word width
    localparam int STAT_W = 4; // status field width
    localparam int IRQ_W = 3; // number of event bits
    localparam int IRQ_DONE = 0; // a test finished
    localparam int IRQ_FAIL = 1; // a test finished with a nonzero result
    localparam int IRQ_HALT = 2; // power-up test failed and is looping

    // ------------------------------------------------------------
    // subtest identities (bit index in the result word, except the precheck)
    // ------------------------------------------------------------
    localparam logic [3:0] ID_ROM = 4'h0; // program memory
    localparam logic [3:0] ID_RAM = 4'h1; // working memory
    localparam logic [3:0] ID_NVM = 4'h2; // nonvolatile memory
    localparam logic [3:0] ID_OPTO = 4'h3; // optical isolator
    localparam logic [3:0] ID_POT = 4'h4; // digital potentiometer
    localparam logic [3:0] ID_LOOP = 4'h5; // serial loopback
    localparam logic [3:0] ID_VMAX = 4'h6; // maximum output
    localparam logic [3:0] ID_VMIN = 4'h7; // minimum output
    localparam logic [3:0] ID_QSC = 4'h8; // quarter-scale output
    localparam logic [3:0] ID_QRB = 4'h9; // quarter-scale readback
    localparam logic [3:0] ID_PRE = 4'hA; // converter, limit and amplifier check
    localparam logic [3:0] STEP_PRE = 4'h6; // full-test step that runs the precheck
    localparam logic [3:0] LAST_PU = 4'h5; // last power-up step
    localparam logic [3:0] LAST_CONF = 4'h4; // last confidence step
    localparam logic [3:0] LAST_FULL = 4'hA; // last full-test step
    localparam logic [3:0] STEP_ONE = 4'h1; // step increment

    // ------------------------------------------------------------
    // beep counts and switch pattern
    // ------------------------------------------------------------
    localparam logic [2:0] BEEPS_MEM = 3'h1;
    localparam logic [2:0] BEEPS_NVM = 3'h2;
    localparam logic [2:0] BEEPS_OPTO = 3'h3;
    localparam logic [2:0] BEEPS_POT = 3'h6;
    localparam logic [2:0] BEEPS_LOOP = 3'h5;
    localparam logic [2:0] BEEPS_NONE = 3'h0;
    localparam logic [2:0] READY_BEEPS = 3'h3; // ready-for-initialization signal
    localparam logic [4:0] SW_ALL_ONES = 5'h1F; // switch pattern that skips power-up

    // which test the sequencer is running
    typedef enum logic [1:0] {
        M_PU = 2'b00,
        M_CONF = 2'b01,
        M_FULL = 2'b10
    } test_mode_t;

    // sequencer states
    typedef enum logic [2:0] {
        S_CAPT = 3'b000,
        S_SKIP = 3'b001,
        S_IDLE = 3'b010,
        S_ISSUE = 3'b011,
        S_WAIT = 3'b100,
        S_BEEP = 3'b101
    } seq_state_t;
endpackage

// *** beep_sequencer.sv ***
// beeper driver: counted beep groups and an even on/off toggle
`timescale 1ns/1ps
module beep_sequencer #(
    parameter int ON_CYCLES = bist_pkg::BEEP_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic start,
    input wire logic [2:0] count,
    input wire logic toggle,
    output logic beep,
    output logic busy
);
    import bist_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] tmr_q; // cycles into the current on or off period
    logic [2:0] left_q; // beeps still to sound
    logic on_q; // beeper drive
    logic act_q; // a counted group is in progress

    wire tick = (tmr_q == 32'(ON_CYCLES - 1));
    wire run = act_q | toggle;

    // period timer, held at zero while neither a group nor the toggle runs
    always_ff @(posedge clock) begin
        if (srst) begin
            tmr_q <= 32'h0000_0000;
        end else if (ce) begin
            tmr_q <= (!run || tick) ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
        end
    end

    // on and off periods are equal; a trailing gap keeps groups apart
    always_ff @(posedge clock) begin
        if (srst) begin
            on_q <= 1'b0;
            act_q <= 1'b0;
            left_q <= BEEPS_NONE;
        end else if (ce) begin
            if (toggle) begin
                // free-running toggle overrides counted groups
                act_q <= 1'b0;
                if (tick) begin
                    on_q <= !on_q;
                end
            end else if (start && !act_q) begin
                act_q <= 1'b1;
                on_q <= 1'b1;
                left_q <= count;
            end else if (act_q && tick) begin
                if (on_q) begin
                    on_q <= 1'b0;
                    left_q <= left_q - 3'h1;
                end else if (left_q != BEEPS_NONE) begin
                    on_q <= 1'b1;
                end else begin
                    act_q <= 1'b0;
                end
            end else if (!act_q) begin
                on_q <= 1'b0;
            end
        end
    end

    assign beep = on_q;
    assign busy = act_q;
endmodule // beep_sequencer

// *** built_in_self_test_unit.sv ***
// self test sequencer with apb registers, error reporting and beeper
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
// Operation
// RQ1 - result zero on pass, else failed-subtest bits
// RQ2 - run all subtests, accumulate every failure
// RQ3 - both tests report bits zero to four
// RQ4 - bits five to nine only from full test; the power-up test also sets bit five
// RQ5 - power-up failure beeps identify the subtest
// RQ6 - failed power-up subtest repeats forever
// RQ7 - all-ones switches skip the power-up test
// RQ8 - after skip, toggle beeper until address valid
// RQ9 - confidence test leaves supply output alone
// RQ10 - analog precheck gates the output subtests
// RQ11 - every failure queues error and beeps; the code beeps only for subtests zero to five
// RQ12 - missing calibration fails nonvolatile memory subtest
// RQ13 - three ready beeps once address is set
// RQ14 - result held until next test starts
module built_in_self_test_unit #(
    parameter int BEEP_CYCLES = bist_pkg::BEEP_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bist_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [4:0] address_switch_bank,
    input wire logic cal_stored,
    output logic subtest_req,
    output logic [3:0] subtest_id,
    input wire logic subtest_done,
    input wire logic subtest_fail,
    output logic err_push,
    output logic [3:0] err_code,
    output logic beeper
);
    import bist_pkg::*;

    // ------------------------------------------------------------
    // decoding functions
    // ------------------------------------------------------------
    // full test slots the analog precheck in ahead of the output subtests
    function automatic logic [3:0] seq_id(test_mode_t m, logic [3:0] s);
        seq_id = (m != M_FULL || s < STEP_PRE) ? s : (s == STEP_PRE) ? ID_PRE : s - STEP_ONE;
    endfunction

    // beep count for a failed subtest; output subtests stay silent
    function automatic logic [2:0] beep_of(logic [3:0] id);
        case (id)
            ID_ROM, ID_RAM: beep_of = BEEPS_MEM;
            ID_NVM: beep_of = BEEPS_NVM;
            ID_OPTO: beep_of = BEEPS_OPTO;
            ID_POT: beep_of = BEEPS_POT;
            ID_LOOP: beep_of = BEEPS_LOOP;
            default: beep_of = BEEPS_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    seq_state_t st_q; // sequencer state
    seq_state_t st_d; // its next value
    test_mode_t mode_q; // running or last test
    logic [3:0] step_q; // position in the test list
    logic [RES_W-1:0] result_q; // accumulated failure bits
    logic fail_q; // current subtest failed
    logic pre_fail_q; // analog precheck failed this run
    logic halt_q; // power-up failure seen, looping
    logic valid_q; // result_q holds a finished test
    logic err_push_q; // error queue push pulse
    logic [3:0] err_code_q; // subtest that failed
    logic beep_start_q; // beeper group request
    logic [2:0] beep_cnt_q; // beeps in that group
    logic beep_busy; // beeper sounding a group
    logic [31:0] prdata_q; // read data caught in setup
    logic [IRQ_W-1:0] irq_stat_q; // sticky events
    logic [IRQ_W-1:0] irq_en_q; // event enables

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire sel_ctrl = (paddr == OFS_CTRL);
    wire sel_status = (paddr == OFS_STATUS);
    wire sel_result = (paddr == OFS_RESULT);
    wire sel_stat = (paddr == OFS_IRQ_STAT);
    wire sel_en = (paddr == OFS_IRQ_EN);
    wire sel_clr = (paddr == OFS_IRQ_CLR);
    wire mapped = sel_ctrl | sel_status | sel_result | sel_stat | sel_en | sel_clr;
    // starts are ignored unless the sequencer is idle
    wire idle = (st_q == S_IDLE);
    wire start_conf = wr & sel_ctrl & pwdata[CTRL_CONF] & idle;
    wire start_full = wr & sel_ctrl & pwdata[CTRL_FULL] & idle & !start_conf;
    wire start_any = start_conf | start_full;

    // ------------------------------------------------------------
    // sequencer decode
    // ------------------------------------------------------------
    wire [3:0] cur_id = seq_id(mode_q, step_q);
    wire [3:0] last_step = (mode_q == M_FULL) ? LAST_FULL :
                           (mode_q == M_CONF) ? LAST_CONF : LAST_PU;
    wire last = (step_q == last_step);
    wire sw_all = (address_switch_bank == SW_ALL_ONES);
    // output subtests are not driven after a failed precheck [RQ10]
    wire forced = (mode_q == M_FULL) & pre_fail_q & (cur_id >= ID_VMAX) & (cur_id <= ID_QRB);
    // no stored calibration means the nonvolatile memory check fails [RQ12]
    wire fail_now = subtest_fail | ((cur_id == ID_NVM) & !cal_stored);
    wire rec_fail = ((st_q == S_WAIT) & subtest_done & fail_now) | ((st_q == S_ISSUE) & forced);
    wire beep_idle = !beep_busy & !beep_start_q;
    wire retry = (mode_q == M_PU) & halt_q;
    wire leave_beep = (st_q == S_BEEP) & beep_idle;
    wire step_adv = leave_beep & !retry & !last;
    wire done_ev = leave_beep & !retry & last;
    wire [IRQ_W-1:0] ev = {rec_fail & (mode_q == M_PU), done_ev & (result_q != '0), done_ev};
    wire [IRQ_W-1:0] clr = (wr & sel_clr) ? pwdata[IRQ_W-1:0] : '0;
    wire [STAT_W-1:0] status = {valid_q, halt_q, st_q == S_SKIP, !idle};
    wire [31:0] rd_mux = sel_status ? 32'(status) :
                         sel_result ? 32'(result_q) :
                         sel_stat ? 32'(irq_stat_q) :
                         sel_en ? 32'(irq_en_q) : 32'h0000_0000;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            // power-up entry: skip the test on an all-ones switch bank [RQ7]
            S_CAPT: st_d = sw_all ? S_SKIP : S_ISSUE;
            // wait for a real address before normal operation [RQ8]
            S_SKIP: if (!sw_all) st_d = S_IDLE;
            S_IDLE: if (start_any) st_d = S_ISSUE;
            S_ISSUE: st_d = forced ? S_BEEP : S_WAIT;
            S_WAIT: if (subtest_done) st_d = S_BEEP;
            // a failed power-up subtest loops here and never reaches idle [RQ6]
            S_BEEP: if (beep_idle) st_d = (retry || !last) ? S_ISSUE : S_IDLE;
            default: st_d = S_CAPT;
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= S_CAPT;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // test selection and step; a failure stops the walk only in the power-up test [RQ2]
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q <= M_PU;
            step_q <= 4'h0;
        end else if (ce) begin
            if (start_any) begin
                mode_q <= start_conf ? M_CONF : M_FULL;
                step_q <= 4'h0;
            end else if (step_adv) begin
                step_q <= step_q + STEP_ONE;
            end
        end
    end

    // result word: cleared at start, one bit per failed subtest except the precheck, then held [RQ1] [RQ14]
    always_ff @(posedge clock) begin
        if (srst) begin
            result_q <= '0;
        end else if (ce) begin
            if (start_any) begin
                result_q <= '0;
            end else if (rec_fail && cur_id < ID_PRE) begin
                result_q[cur_id] <= 1'b1; // [RQ3] [RQ4]
            end
        end
    end

    // per-subtest failure, precheck outcome, power-up halt and result valid
    always_ff @(posedge clock) begin
        if (srst) begin
            fail_q <= 1'b0;
            pre_fail_q <= 1'b0;
            halt_q <= 1'b0;
            valid_q <= 1'b0;
        end else if (ce) begin
            if (st_q == S_ISSUE) begin
                fail_q <= forced;
            end else if (st_q == S_WAIT && subtest_done) begin
                fail_q <= fail_now;
            end
            pre_fail_q <= start_any ? 1'b0 : (pre_fail_q | (rec_fail & (cur_id == ID_PRE)));
            halt_q <= halt_q | (rec_fail & (mode_q == M_PU));
            valid_q <= start_any ? 1'b0 : (valid_q | done_ev);
        end
    end

    // each failure pushes an error entry; subtests zero to five also ask for their beep group [RQ11] [RQ5]
    always_ff @(posedge clock) begin
        if (srst) begin
            err_push_q <= 1'b0;
            err_code_q <= 4'h0;
            beep_start_q <= 1'b0;
            beep_cnt_q <= BEEPS_NONE;
        end else if (ce) begin
            err_push_q <= rec_fail;
            if (rec_fail) begin
                err_code_q <= cur_id;
            end
            // leaving the skip wait gives the ready signal [RQ13]
            beep_start_q <= (rec_fail & (beep_of(cur_id) != BEEPS_NONE)) |
                            ((st_q == S_SKIP) & !sw_all);
            beep_cnt_q <= (st_q == S_SKIP) ? READY_BEEPS : beep_of(cur_id);
        end
    end

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    // read data is caught in the setup cycle so it comes from a flop
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata_q <= rd_mux;
        end
    end

    // sticky events: a new event wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
        end else if (ce) begin
            irq_stat_q <= (irq_stat_q & ~clr) | ev;
            if (wr && sel_en) begin
                irq_en_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // beeper; the skip state runs it as an even toggle [RQ8]
    beep_sequencer #(.ON_CYCLES(BEEP_CYCLES)) u_beep (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .start(beep_start_q),
        .count(beep_cnt_q),
        .toggle(st_q == S_SKIP),
        .beep(beeper),
        .busy(beep_busy)
    );

    // outputs; confidence list stops at the potentiometer, output untouched [RQ9]
    assign subtest_req = (st_q == S_ISSUE) & !forced;
    assign subtest_id = cur_id;
    assign err_push = err_push_q;
    assign err_code = err_code_q;
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = acc & !mapped;
    assign irq = |(irq_stat_q & irq_en_q);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_rq1;
        err_push_q && err_code_q < ID_PRE |-> result_q != '0;
    endproperty
    a_rq1: assert property (p_rq1) else $error("failure left result zero"); // [RQ1]
    property p_rq2;
        ce && step_adv |=> st_q == S_ISSUE && step_q == $past(step_q) + STEP_ONE;
    endproperty
    a_rq2: assert property (p_rq2) else $error("sequence did not advance"); // [RQ2]
    property p_rq3;
        ce && st_q == S_WAIT && subtest_done && fail_now && cur_id < ID_PRE
            |=> result_q[$past(cur_id)];
    endproperty
    a_rq3: assert property (p_rq3) else $error("failure bit not recorded"); // [RQ3]
    property p_rq4;
        mode_q == M_CONF |-> result_q[RES_W-1:5] == '0;
    endproperty
    a_rq4: assert property (p_rq4) else $error("confidence test set full-test bit"); // [RQ4]
    property p_rq5;
        err_push_q && err_code_q == ID_POT |-> beep_start_q && beep_cnt_q == BEEPS_POT;
    endproperty
    a_rq5: assert property (p_rq5) else $error("wrong beep count"); // [RQ5]
    property p_rq6;
        ce && leave_beep && retry |=> st_q == S_ISSUE && $stable(step_q);
    endproperty
    a_rq6: assert property (p_rq6) else $error("power-up failure not repeated"); // [RQ6]
    property p_rq7;
        ce && st_q == S_CAPT && sw_all |=> st_q == S_SKIP;
    endproperty
    a_rq7: assert property (p_rq7) else $error("power-up test not skipped"); // [RQ7]
    property p_rq8;
        ce && st_q == S_SKIP && sw_all |=> st_q == S_SKIP ##0 !subtest_req;
    endproperty
    a_rq8: assert property (p_rq8) else $error("left skip wait early"); // [RQ8]
    property p_rq9;
        subtest_req && mode_q == M_CONF |-> subtest_id <= ID_POT;
    endproperty
    a_rq9: assert property (p_rq9) else $error("confidence test touched output"); // [RQ9]
    property p_rq10;
        st_q == S_ISSUE && pre_fail_q && cur_id >= ID_VMAX && cur_id <= ID_QRB
            |-> !subtest_req;
    endproperty
    a_rq10: assert property (p_rq10) else $error("output driven after precheck fail"); // [RQ10]
    property p_rq11;
        ce && rec_fail |=> err_push_q && err_code_q == $past(cur_id);
    endproperty
    a_rq11: assert property (p_rq11) else $error("failure not queued"); // [RQ11]
    property p_rq12;
        ce && st_q == S_WAIT && subtest_done && cur_id == ID_NVM && !cal_stored
            |=> result_q[ID_NVM];
    endproperty
    a_rq12: assert property (p_rq12) else $error("uncalibrated memory passed"); // [RQ12]
    property p_rq13;
        ce && st_q == S_SKIP && !sw_all |=> beep_start_q && beep_cnt_q == READY_BEEPS;
    endproperty
    a_rq13: assert property (p_rq13) else $error("no ready beeps"); // [RQ13]
    property p_rq14;
        ce && idle && !start_any |=> $stable(result_q);
    endproperty
    a_rq14: assert property (p_rq14) else $error("result changed while idle"); // [RQ14]
    c_conf_pass: cover property (done_ev && mode_q == M_CONF && result_q == '0);
    c_full_fail: cover property (done_ev && mode_q == M_FULL && result_q != '0);
    c_pu_halt: cover property (leave_beep && retry);
    c_skip: cover property (st_q == S_SKIP ##1 st_q == S_IDLE);
endmodule // built_in_self_test_unit

// *** subtest_responder.sv ***
// partner model: the outside subtest runner that answers the self test unit
`timescale 1ns/1ps
module subtest_responder (
    input wire logic clock,
    input wire logic srst,
    input wire logic subtest_req,
    input wire logic [3:0] subtest_id,
    input wire logic [10:0] fail_mask,
    output logic subtest_done,
    output logic subtest_fail
);
    logic [1:0] cnt_q; // cycles left before the answer
    logic [3:0] id_q; // subtest being run
    logic slow_q; // alternates prompt and slow answers
    // one answer per request; the fail line is junk outside the done pulse
    always @(posedge clock) begin
        subtest_done <= !srst && cnt_q == 2'h1;
        subtest_fail <= srst ? 1'b0 : (cnt_q == 2'h1) ? fail_mask[id_q] : ~subtest_fail;
        if (srst) begin
            cnt_q <= 2'h0;
            slow_q <= 1'b0;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end else if (subtest_req) begin
            id_q <= subtest_id;
            cnt_q <= slow_q ? 2'h3 : 2'h1;
            slow_q <= ~slow_q;
        end
    end
endmodule // subtest_responder

// *** built_in_self_test_unit_tb_top.sv ***
// testbench for the built-in self test unit
`timescale 1ns/1ps
module built_in_self_test_unit_tb_top;
    import bist_pkg::*;
    // ------------------------------------------------------------
    // signals and test table
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, subtest_req, subtest_done, subtest_fail;
    logic err_push, beeper, err_seen;
    logic [3:0] subtest_id, err_code;
    logic [4:0] address_switch_bank = 5'h03;
    logic cal_stored = 1'b1;
    logic [10:0] fail_mask = '0;
    int mismatches = 0;
    int samples_checked = 0;
    int pushes = 0; // error queue pushes seen
    int reqs = 0; // subtest requests seen
    int hi;
    // kind, failing subtests, calibration stored, result, pushes
    typedef struct packed {
        logic [1:0] kind; logic [10:0] mask; logic cal; logic [9:0] res; logic [3:0] err;
    } row_t;
    row_t rows [6] = '{
        '{2'h1, 11'h000, 1'b1, 10'h000, 4'h0}, '{2'h3, 11'h7ff, 1'b1, 10'h01f, 4'h5},
        '{2'h2, 11'h3e0, 1'b1, 10'h3e0, 4'h5}, '{2'h2, 11'h400, 1'b1, 10'h3c0, 4'h5},
        '{2'h1, 11'h000, 1'b0, 10'h004, 4'h1}, '{2'h2, 11'h015, 1'b1, 10'h015, 4'h3}};
    // ------------------------------------------------------------
    // clock, design and partner
    // ------------------------------------------------------------
    always #5 clock = ~clock;
    // short beeps keep failing runs brief
    built_in_self_test_unit #(.BEEP_CYCLES(4)) u_built_in_self_test_unit (.clock(clock),
        .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .address_switch_bank(address_switch_bank), .cal_stored(cal_stored),
        .subtest_req(subtest_req), .subtest_id(subtest_id), .subtest_done(subtest_done),
        .subtest_fail(subtest_fail), .err_push(err_push), .err_code(err_code), .beeper(beeper));
    subtest_responder u_subtest_responder (.clock(clock), .srst(srst),
        .subtest_req(subtest_req), .subtest_id(subtest_id), .fail_mask(fail_mask),
        .subtest_done(subtest_done), .subtest_fail(subtest_fail));
    // count pulses as the design drives them
    always @(posedge clock) begin
        if (err_push === 1'b1) pushes <= pushes + 1;
        if (subtest_req === 1'b1) reqs <= reqs + 1;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one apb transfer; the request is held until pready is seen high
    task apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            close_out();
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll the busy bit under a bound
    task wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 500);
        if (rd[0] !== 1'b0) begin
            mismatches++;
            close_out();
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        wait_idle();
        foreach (rows[i]) begin
            fail_mask <= rows[i].mask;
            cal_stored <= rows[i].cal;
            pushes = 0;
            apb(1'b1, OFS_CTRL, 32'(rows[i].kind));
            wait_idle();
            apb(1'b0, OFS_RESULT, 32'h0000_0000);
            check(rd, 32'(rows[i].res));
            check(32'(pushes), 32'(rows[i].err));
            $display("table row %0d finished", i);
        end
        apb(1'b0, OFS_RESULT, 32'h0000_0000);
        check(rd, 32'h0000_0015);
        // sticky events, enable, clear, and an unmapped address
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0002);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
        #1;
        check(32'(irq), 32'h0000_0001);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        check({err_seen, rd[30:0]}, 32'h8000_0000);
        $display("register test finished");
        // all-ones switches: no subtests, even beeper toggle
        fail_mask <= 11'h000;
        address_switch_bank <= SW_ALL_ONES;
        srst <= 1'b1;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        reqs = 0;
        repeat (20) @(posedge clock);
        hi = 0;
        repeat (40) begin
            @(posedge clock);
            hi += int'(beeper === 1'b1);
        end
        check(32'(hi), 32'h0000_0014);
        check(32'(reqs), 32'h0000_0000);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        check(32'(rd[3:0]), 32'h0000_0003);
        ce <= 1'b0;
        @(posedge clock) hi = int'(beeper);
        repeat (4) @(posedge clock);
        check(32'(beeper), 32'(hi));
        ce <= 1'b1;
        address_switch_bank <= 5'h03;
        wait_idle();
        $display("skip test finished");
        // failing power-up subtest is retried and never goes idle
        fail_mask <= 11'h008;
        srst <= 1'b1;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        pushes = 0;
        repeat (200) @(posedge clock);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        check({30'h0, rd[2], rd[0]}, 32'h0000_0003);
        check(32'(pushes > 1), 32'h0000_0001);
        check(32'(err_code), 32'(ID_OPTO));
        $display("power-up failure test finished");
        close_out();
    end
endmodule // built_in_self_test_unit_tb_top
